// >>> ppfm_pkg.sv
package ppfm_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_P5_FUNC = 12'h000;
  localparam logic [11:0] OFF_P5_DIR = 12'h004;
  localparam logic [11:0] OFF_P5_DATA = 12'h008;
  localparam logic [11:0] OFF_P7_DIR = 12'h00c;
  localparam logic [11:0] OFF_P7_DATA = 12'h010;
  localparam logic [11:0] OFF_P8_DIR = 12'h014;
  localparam logic [11:0] OFF_P8_DATA = 12'h018;
  localparam int P5_WAKE_N = 6;
  localparam int P5_TRIG_BIT = 5;
  localparam int P7_OUT_BIT = 6;
  localparam int P7_CLK_BIT = 5;
  localparam int P7_RST_BIT = 4;
  localparam int P8_CLK_BIT = 0;
  localparam logic [7:0] P7_IMPL_MASK = 8'h70;
  localparam logic [7:0] P7_RSVD_READ = 8'h8f;
  localparam logic [7:0] P5_FUNC_MASK = 8'h3f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] TV_SEL_GPIO = 4'h0;
endpackage

// >>> ppfm_top.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Port5 low pins: wake select 0 gives GPIO by direction, 1 gives wake input.
// - Port5 pin 5 in wake mode also feeds the converter trigger input.
// - Port7 direction bits 6..4: 1 output, 0 input, reset 0.
// - Timer-V output select overrides port7 pin 6 direction.
// - Select 0000 leaves pin 6 GPIO; any other value drives timer-V output.
// - Port7 pins 5 and 4 always feed timer-V clock and reset inputs.
// - Port7 data register holds values driven onto output pins.
// - Port7 data read: latch when direction 1, synced pin when direction 0.
// - Port7 data bits 7 and 3..0 read 1 and ignore writes.
// - Timer-W claims take priority over port8 settings on pins 4..1.
// - Port8 pin 0 always feeds the timer-W clock input.
// - Port5 direction bit 1 output, 0 input, only while a general port.
module ppfm_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] p5PinIn,
  output logic [7:0] p5PinOut,
  output logic [7:0] p5PinOe,
  input wire logic [7:0] p7PinIn,
  output logic [7:0] p7PinOut,
  output logic [7:0] p7PinOe,
  input wire logic [7:0] p8PinIn,
  output logic [7:0] p8PinOut,
  output logic [7:0] p8PinOe,
  input wire logic [3:0] timerVOutputSelect,
  input wire logic timerVOutput,
  input wire logic [4:1] timerWClaim,
  input wire logic [4:1] timerWOut,
  output logic timerVClockIn,
  output logic timerVResetIn,
  output logic timerWClockIn,
  output logic [3:0] timerWIoIn,
  output logic [5:0] wakeIn,
  output logic converterTriggerIn
);
  logic [7:0] p5Func_q, p5Func_d, p5Dir_q, p5Dir_d, p5Data_q, p5Data_d;
  logic [7:0] p7Dir_q, p7Dir_d, p7Data_q, p7Data_d, p8Dir_q, p8Dir_d, p8Data_q, p8Data_d;
  logic [7:0] s5a_q, s5b_q, s7a_q, s7b_q, s8a_q, s8b_q;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [7:0] p5Out_d, p5Oe_d, p7Out_d, p7Oe_d, p8Out_d, p8Oe_d;
  logic tvClk_d, tvRst_d, twClk_d, trig_d;
  logic [3:0] twIo_d;
  logic [5:0] wake_d;
  logic setup, access, wr, tvClaim;
  logic [7:0] wb;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign wb = pwdata[7:0];
  assign tvClaim = timerVOutputSelect != ppfm_pkg::TV_SEL_GPIO;

  // Two stages on every pin before anything reads it.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s5a_q <= 8'h00;
      s5b_q <= 8'h00;
      s7a_q <= 8'h00;
      s7b_q <= 8'h00;
      s8a_q <= 8'h00;
      s8b_q <= 8'h00;
    end else begin
      s5a_q <= p5PinIn;
      s5b_q <= s5a_q;
      s7a_q <= p7PinIn;
      s7b_q <= s7a_q;
      s8a_q <= p8PinIn;
      s8b_q <= s8a_q;
    end
  end

  always_comb begin
    p5Func_d = p5Func_q;
    p5Dir_d = p5Dir_q;
    p5Data_d = p5Data_q;
    p7Dir_d = p7Dir_q;
    p7Data_d = p7Data_q;
    p8Dir_d = p8Dir_q;
    p8Data_d = p8Data_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (paddr == ppfm_pkg::OFF_P5_FUNC) begin
      if (wr) p5Func_d = wb & ppfm_pkg::P5_FUNC_MASK;
      prdata_d[7:0] = p5Func_q;
    end else if (paddr == ppfm_pkg::OFF_P5_DIR) begin
      if (wr) p5Dir_d = wb;
    end else if (paddr == ppfm_pkg::OFF_P5_DATA) begin
      if (wr) p5Data_d = wb;
      prdata_d[7:0] = (p5Dir_q & p5Data_q) | (~p5Dir_q & s5b_q);
    end else if (paddr == ppfm_pkg::OFF_P7_DIR) begin
      if (wr) p7Dir_d = wb & ppfm_pkg::P7_IMPL_MASK;
    end else if (paddr == ppfm_pkg::OFF_P7_DATA) begin
      if (wr) p7Data_d = wb & ppfm_pkg::P7_IMPL_MASK;
      prdata_d[7:0] = ((p7Dir_q & p7Data_q) | (~p7Dir_q & s7b_q & ppfm_pkg::P7_IMPL_MASK))
                      | ppfm_pkg::P7_RSVD_READ;
    end else if (paddr == ppfm_pkg::OFF_P8_DIR) begin
      if (wr) p8Dir_d = wb;
    end else if (paddr == ppfm_pkg::OFF_P8_DATA) begin
      if (wr) p8Data_d = wb;
      prdata_d[7:0] = (p8Dir_q & p8Data_q) | (~p8Dir_q & s8b_q);
    end else begin
      pslverr_d = setup;
    end
    if (!setup) begin
      prdata_d = prdata;
      pslverr_d = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p5Oe_d[i] = p5Dir_q[i];
    end
    p5Oe_d[5:0] = p5Dir_q[5:0] & ~p5Func_q[5:0];
    p5Out_d = p5Data_q & p5Oe_d;
    wake_d = s5b_q[5:0] & p5Func_q[5:0];
    trig_d = p5Func_q[ppfm_pkg::P5_TRIG_BIT] && s5b_q[ppfm_pkg::P5_TRIG_BIT];
    p7Oe_d = p7Dir_q;
    p7Out_d = p7Data_q & p7Dir_q;
    if (tvClaim) begin
      p7Oe_d[ppfm_pkg::P7_OUT_BIT] = 1'b1;
      p7Out_d[ppfm_pkg::P7_OUT_BIT] = timerVOutput;
    end
    tvClk_d = s7b_q[ppfm_pkg::P7_CLK_BIT];
    tvRst_d = s7b_q[ppfm_pkg::P7_RST_BIT];
    p8Oe_d = p8Dir_q;
    p8Out_d = p8Data_q & p8Dir_q;
    for (int j = 1; j < 5; j++) begin
      if (timerWClaim[j]) begin
        p8Oe_d[j] = 1'b1;
        p8Out_d[j] = timerWOut[j];
      end
    end
    twIo_d = s8b_q[4:1];
    twClk_d = s8b_q[ppfm_pkg::P8_CLK_BIT];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p5Func_q <= 8'h00;
      p5Dir_q <= 8'h00;
      p5Data_q <= 8'h00;
      p7Dir_q <= 8'h00;
      p7Data_q <= 8'h00;
      p8Dir_q <= 8'h00;
      p8Data_q <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      p5PinOut <= 8'h00;
      p5PinOe <= 8'h00;
      p7PinOut <= 8'h00;
      p7PinOe <= 8'h00;
      p8PinOut <= 8'h00;
      p8PinOe <= 8'h00;
      timerVClockIn <= 1'b0;
      timerVResetIn <= 1'b0;
      timerWClockIn <= 1'b0;
      timerWIoIn <= 4'h0;
      wakeIn <= 6'h00;
      converterTriggerIn <= 1'b0;
    end else begin
      p5Func_q <= p5Func_d;
      p5Dir_q <= p5Dir_d;
      p5Data_q <= p5Data_d;
      p7Dir_q <= p7Dir_d;
      p7Data_q <= p7Data_d;
      p8Dir_q <= p8Dir_d;
      p8Data_q <= p8Data_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      p5PinOut <= p5Out_d;
      p5PinOe <= p5Oe_d;
      p7PinOut <= p7Out_d;
      p7PinOe <= p7Oe_d;
      p8PinOut <= p8Out_d;
      p8PinOe <= p8Oe_d;
      timerVClockIn <= tvClk_d;
      timerVResetIn <= tvRst_d;
      timerWClockIn <= twClk_d;
      timerWIoIn <= twIo_d;
      wakeIn <= wake_d;
      converterTriggerIn <= trig_d;
    end
  end

  // Pin outputs are registered, so every check on them below allows one cycle of lag.
  // A pin level reaches a timer input after three edges: two sync stages, then the output flop.
  sequence p7_read_setup_s;
    setup && !pwrite && paddr == ppfm_pkg::OFF_P7_DATA;
  endsequence

  property wake_blocks_drive_p;
    @(posedge ref_clk) disable iff (!resetn)
      p5Func_q[0] |=> !p5PinOe[0];
  endproperty
  wake_blocks_drive_a: assert property (wake_blocks_drive_p)
    else $error("wake pin driven");

  property wake_value_p;
    @(posedge ref_clk) disable iff (!resetn)
      p5Func_q[3] |=> wakeIn[3] == $past(s5b_q[3]);
  endproperty
  wake_value_a: assert property (wake_value_p)
    else $error("wake input lost");

  property trig_follows_pin_p;
    @(posedge ref_clk) disable iff (!resetn)
      $stable(p5Func_q) |=> converterTriggerIn ==
        ($past(p5Func_q[ppfm_pkg::P5_TRIG_BIT]) && $past(s5b_q[ppfm_pkg::P5_TRIG_BIT]));
  endproperty
  trig_follows_pin_a: assert property (trig_follows_pin_p)
    else $error("trigger mismatch");

  property p7_dir_oe_p;
    @(posedge ref_clk) disable iff (!resetn)
      !tvClaim |=> p7PinOe[6:4] == $past(p7Dir_q[6:4]);
  endproperty
  p7_dir_oe_a: assert property (p7_dir_oe_p)
    else $error("p7 oe wrong");

  property p7_dir_rsvd_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> (p7Dir_q & ~ppfm_pkg::P7_IMPL_MASK) == 8'h00;
  endproperty
  p7_dir_rsvd_a: assert property (p7_dir_rsvd_p)
    else $error("p7 reserved direction set");

  property tv_claim_pin_p;
    @(posedge ref_clk) disable iff (!resetn)
      tvClaim |=> p7PinOe[6] && p7PinOut[6] == $past(timerVOutput);
  endproperty
  tv_claim_pin_a: assert property (tv_claim_pin_p)
    else $error("timer v not driving");

  property tv_idle_gpio_p;
    @(posedge ref_clk) disable iff (!resetn)
      !tvClaim && !p7Dir_q[6] |=> !p7PinOe[6];
  endproperty
  tv_idle_gpio_a: assert property (tv_idle_gpio_p)
    else $error("p7 pin6 driven");

  property tv_inputs_fed_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> ##3 timerVClockIn == $past(p7PinIn[5], 3);
  endproperty
  tv_inputs_fed_a: assert property (tv_inputs_fed_p)
    else $error("tv clock lost");

  property tv_reset_fed_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> ##3 timerVResetIn == $past(p7PinIn[4], 3);
  endproperty
  tv_reset_fed_a: assert property (tv_reset_fed_p)
    else $error("tv reset lost");

  property p7_latch_drive_p;
    @(posedge ref_clk) disable iff (!resetn)
      p7Dir_q[4] |=> p7PinOut[4] == $past(p7Data_q[4]);
  endproperty
  p7_latch_drive_a: assert property (p7_latch_drive_p)
    else $error("latch not driven");

  property p7_read_value_p;
    @(posedge ref_clk) disable iff (!resetn)
      p7_read_setup_s |=> pready && prdata[7:0] == (ppfm_pkg::P7_RSVD_READ
        | ($past(p7Dir_q) & $past(p7Data_q))
        | (~$past(p7Dir_q) & $past(s7b_q) & ppfm_pkg::P7_IMPL_MASK));
  endproperty
  p7_read_value_a: assert property (p7_read_value_p)
    else $error("p7 read wrong");

  property p7_rsvd_clear_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> (p7Data_q & ~ppfm_pkg::P7_IMPL_MASK) == 8'h00;
  endproperty
  p7_rsvd_clear_a: assert property (p7_rsvd_clear_p)
    else $error("p7 reserved bit stored");

  property tw_priority_p;
    @(posedge ref_clk) disable iff (!resetn)
      timerWClaim[2] |=> p8PinOe[2] && p8PinOut[2] == $past(timerWOut[2]);
  endproperty
  tw_priority_a: assert property (tw_priority_p)
    else $error("timer w lost pin");

  property tw_pin4_claim_p;
    @(posedge ref_clk) disable iff (!resetn)
      timerWClaim[4] |=> p8PinOe[4] && p8PinOut[4] == $past(timerWOut[4]);
  endproperty
  tw_pin4_claim_a: assert property (tw_pin4_claim_p)
    else $error("timer w lost pin 4");

  property tw_clock_fed_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> ##3 timerWClockIn == $past(p8PinIn[0], 3);
  endproperty
  tw_clock_fed_a: assert property (tw_clock_fed_p)
    else $error("tw clock lost");

  property p5_gpio_dir_p;
    @(posedge ref_clk) disable iff (!resetn)
      !p5Func_q[1] |=> p5PinOe[1] == $past(p5Dir_q[1]);
  endproperty
  p5_gpio_dir_a: assert property (p5_gpio_dir_p)
    else $error("p5 direction ignored");

  property sync_two_stage_p;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> ##2 s7b_q == $past(p7PinIn, 2);
  endproperty
  sync_two_stage_a: assert property (sync_two_stage_p)
    else $error("pin sync depth wrong");
endmodule

// >>> ppfm_far_model.sv
`timescale 1ns/1ps
// Board side of the pins: each line carries the chip's value while its enable is high.
// Otherwise it carries the level that the bench commands, so nothing floats.
module ppfm_far_model (
  input wire logic [7:0] p5PinOut,
  input wire logic [7:0] p5PinOe,
  input wire logic [7:0] p7PinOut,
  input wire logic [7:0] p7PinOe,
  input wire logic [7:0] p8PinOut,
  input wire logic [7:0] p8PinOe,
  input wire logic [7:0] ext5,
  input wire logic [7:0] ext7,
  input wire logic [7:0] ext8,
  output logic [7:0] p5PinIn,
  output logic [7:0] p7PinIn,
  output logic [7:0] p8PinIn
);
  assign p5PinIn = (p5PinOe & p5PinOut) | (~p5PinOe & ext5);
  assign p7PinIn = (p7PinOe & p7PinOut) | (~p7PinOe & ext7);
  assign p8PinIn = (p8PinOe & p8PinOut) | (~p8PinOe & ext8);
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] p5PinOut, p5PinOe, p7PinOut, p7PinOe, p8PinOut, p8PinOe;
  logic [7:0] p5PinIn, p7PinIn, p8PinIn, ext5 = 0, ext7 = 0, ext8 = 0;
  logic [3:0] timerVOutputSelect = 0, timerWIoIn;
  logic timerVOutput = 0, timerVClockIn, timerVResetIn, timerWClockIn, converterTriggerIn;
  logic [4:1] timerWClaim = 0, timerWOut = 0;
  logic [5:0] wakeIn;
  int failures = 0, checks = 0, cycles = 0;
  ppfm_top i_ppfm_top (.*);
  ppfm_far_model i_ppfm_far_model (.*);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task close_out;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One APB transfer; request held until pready is seen high at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task t_port7;
    chk(p7PinOe, 8'h00);
    apb(0, ppfm_pkg::OFF_P7_DATA, 0);
    chk(rd, 32'h8f);
    apb(1, ppfm_pkg::OFF_P7_DIR, 32'hff);
    apb(1, ppfm_pkg::OFF_P7_DATA, 32'h50);
    apb(0, ppfm_pkg::OFF_P7_DATA, 0);
    chk(rd, 32'hdf);
    tick(4);
    chk(p7PinOe, 8'h70);
    chk(p7PinOut, 8'h50);
    chk({timerVClockIn, timerVResetIn}, 2'b01);
    ext7 <= 8'h20;
    apb(1, ppfm_pkg::OFF_P7_DIR, 0);
    tick(4);
    apb(0, ppfm_pkg::OFF_P7_DATA, 0);
    chk(rd, 32'haf);
    chk({timerVClockIn, timerVResetIn}, 2'b10);
  endtask
  task t_timer_v;
    ext7 <= 0;
    timerVOutputSelect <= 4'h3;
    timerVOutput <= 1;
    tick(4);
    chk(p7PinOe[6], 1'b1);
    chk(p7PinOut[6], 1'b1);
    timerVOutputSelect <= 4'h0;
    tick(4);
    chk(p7PinOe[6], 1'b0);
  endtask
  task t_port5;
    apb(1, ppfm_pkg::OFF_P5_DIR, 32'h3f);
    apb(1, ppfm_pkg::OFF_P5_FUNC, 32'h3f);
    ext5 <= 8'h2a;
    tick(5);
    chk(p5PinOe, 8'h00);
    chk(wakeIn, 6'h2a);
    chk(converterTriggerIn, 1'b1);
    apb(1, ppfm_pkg::OFF_P5_FUNC, 0);
    tick(3);
    chk(p5PinOe, 8'h3f);
    chk(wakeIn, 6'h00);
    chk(converterTriggerIn, 1'b0);
    apb(1, ppfm_pkg::OFF_P5_DATA, 32'h15);
    tick(2);
    chk(p5PinOut, 8'h15);
    apb(0, ppfm_pkg::OFF_P5_DATA, 0);
    chk(rd, 32'h15);
  endtask
  task t_port8;
    ext8 <= 8'h1f;
    timerWClaim <= 4'b0111;
    timerWOut <= 4'b0101;
    tick(5);
    chk(p8PinOe[3:1], 3'b111);
    chk(p8PinOut[3:1], 3'b101);
    chk(timerWClockIn, 1'b1);
    chk(timerWIoIn, 4'hd);
    timerWClaim <= 4'b1000;
    timerWOut <= 4'b0000;
    tick(5);
    chk(p8PinOe[4:1], 4'b1000);
    chk(timerWIoIn, 4'h7);
    apb(0, 12'h0fc, 0);
    chk(err, 1'b1);
  endtask
  initial begin
    tick(12);
    resetn <= 1;
    t_port7;
    t_timer_v;
    t_port5;
    t_port8;
    close_out;
  end
endmodule
